/* File: src/fpd_defines.svh */
/*
 * Constants of the power-down and identification command block:
 * opcodes, input clock counts, timing figures and pin defaults.
 * Assumes a 100 MHz system clock; included by fpd_top and by the bench only.
 */
`ifndef FPD_DEFINES_SVH
`define FPD_DEFINES_SVH

`define FPD_CLK_MHZ     100

// Opcodes
`define FPD_OP_PD       8'hB9
`define FPD_OP_REL      8'hAB
`define FPD_OP_MD1      8'h90
`define FPD_OP_MD2      8'h92
`define FPD_OP_MD4      8'h94
`define FPD_OP_UID      8'h4B
`define FPD_OP_JID      8'h9F
`define FPD_OP_PAR      8'h5A

// Serial clocks between the opcode and the first output edge
`define FPD_IN_REL      6'd24
`define FPD_IN_MD1      6'd24
`define FPD_IN_MD2      6'd16
`define FPD_IN_MD4      6'd12
`define FPD_IN_UID      6'd32
`define FPD_IN_JID      6'd0
`define FPD_IN_PAR      6'd32
`define FPD_PAR_ADDR    6'd24
`define FPD_OPC_BITS    4'd8

// Power-down entry and release, both longest times
`define FPD_T_DP_NS     3000
`define FPD_DP_CYC      ((`FPD_T_DP_NS * `FPD_CLK_MHZ) / 1000)
`define FPD_T_RES_NS    3000
`define FPD_RES_CYC     ((`FPD_T_RES_NS * `FPD_CLK_MHZ) / 1000)

// Pin reset levels: serial clock, chip select, serial input
`define FPD_PIN_RST     3'b010
`define FPD_OE_OFF      4'h0
`define FPD_OE_W1       4'h2
`define FPD_OE_W2       4'h3
`define FPD_OE_W4       4'hF

`endif

/* File: src/fpd_pkg.sv */
/*
 * Types of the power-down and identification command block.
 * Assumes nothing of its surroundings.
 */
package fpd_pkg;

   typedef enum logic [1:0] {
      FPD_PM_NORMAL,
      FPD_PM_ENTER,
      FPD_PM_DOWN,
      FPD_PM_RELEASE
   } fpd_pm_t;

   typedef enum logic [1:0] {
      FPD_PH_OPC,
      FPD_PH_IN,
      FPD_PH_OUT,
      FPD_PH_IGN
   } fpd_ph_t;

   typedef enum logic [1:0] {
      FPD_W1,
      FPD_W2,
      FPD_W4
   } fpd_wid_t;

endpackage : fpd_pkg

/* File: src/fpd_sync.sv */
/*
 * Two-flop synchroniser, one lane per bit.
 * Assumes inputs that are asynchronous to clock; reset is synchronous.
 */
`timescale 1ns/1ps
module fpd_sync #(
   parameter int               WIDTH = 3,
   parameter logic [WIDTH-1:0] RST   = '0
) (
   // Clock and reset
   input  wire logic             clock,
   input  wire logic             rst_n,
   // Lanes
   input  wire logic [WIDTH-1:0] din,
   output logic      [WIDTH-1:0] dout
);

   logic [WIDTH-1:0] meta_q;

   for (genvar i = 0; i < WIDTH; i++)
   begin : g_lane
      always_ff @(posedge clock)
      begin
         if (!rst_n)
         begin
            meta_q[i] <= RST[i];
            dout[i]   <= RST[i];
         end
         else
         begin
            meta_q[i] <= din[i];
            dout[i]   <= meta_q[i];
         end
      end
   end

endmodule : fpd_sync

/* File: src/fpd_fifo.sv */
/*
 * Flop-based FIFO with valid/ready on both sides and a flush.
 * Assumes DEPTH is a power of two; one clock, synchronous reset.
 */
`timescale 1ns/1ps
module fpd_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 16
) (
   // Clock and reset
   input  wire logic             clock,
   input  wire logic             rst_n,
   input  wire logic             flush,
   // Fill side
   input  wire logic             in_valid,
   output logic                  in_ready,
   input  wire logic [WIDTH-1:0] in_data,
   // Drain side
   output logic                  out_valid,
   input  wire logic             out_ready,
   output logic      [WIDTH-1:0] out_data
);

   localparam int AW = $clog2(DEPTH);

   logic [WIDTH-1:0] mem_q [DEPTH];
   logic [AW-1:0]    wp_q;
   logic [AW-1:0]    rp_q;
   logic [AW:0]      cnt_q;
   logic             push;
   logic             pop;

   assign in_ready  = (cnt_q != DEPTH[AW:0]);
   assign out_valid = (cnt_q != '0);
   assign out_data  = mem_q[rp_q];
   assign push      = in_valid && in_ready;
   assign pop       = out_valid && out_ready;

   always_ff @(posedge clock)
   begin
      if (push)
         mem_q[wp_q] <= in_data;
   end

   always_ff @(posedge clock)
   begin
      if (!rst_n || flush)
      begin
         wp_q  <= '0;
         rp_q  <= '0;
         cnt_q <= '0;
      end
      else
      begin
         if (push)
            wp_q <= wp_q + 1'b1;
         if (pop)
            rp_q <= rp_q + 1'b1;
         if (push && !pop)
            cnt_q <= cnt_q + 1'b1;
         else if (pop && !push)
            cnt_q <= cnt_q - 1'b1;
      end
   end

endmodule : fpd_fifo

/* File: src/fpd_top.sv */
/*
 * Power-down and identification command engine of a serial flash.
 * Assumes serial clock, chip select and serial input arrive
 * asynchronously and are far slower than clock; the erase/program
 * engine drives prog_busy on this clock.
 */
// Behaviour
// RULE1: B9h runs only if select rises after bit 8
// RULE2: Power-down reached within entry time after select rises
// RULE3: Powered down, only ABh is recognised
// RULE4: Reset always starts in normal operation
// RULE5: ABh releases; commands ignored until release time ends
// RULE6: Host keeps select high during release time
// RULE7: ABh plus three dummy bytes returns device identifier
// RULE8: Device identifier repeats until select rises
// RULE9: ABh ignored while busy, cycle unaffected
// RULE10: 90h returns manufacturer then device identifier, serially
// RULE11: 92h address two bits, identifiers two bits a clock
// RULE12: Dual and quad identifiers alternate while clocked
// RULE13: Host sends mode bits Fxh in dual/quad
// RULE14: 94h address four bits, identifiers four bits a clock
// RULE15: 4Bh plus four dummy bytes returns unique identifier
// RULE16: 9Fh returns manufacturer, memory type, capacity bytes
// RULE17: 5Ah table read starts on falling edge 40
// RULE18: Host drives upper address zero, low byte starts
// RULE19: Opcode and address sampled on rising serial clock
// RULE20: Busy flag high while erase/program runs
// RULE21: Table address advances and wraps per byte
// RULE22: Select high ends any read, drivers released
`timescale 1ns/1ps
`include "fpd_defines.svh"
module fpd_top #(
   parameter logic [7:0]  MFR_ID    = 8'hA5,                  // Arbitrary value
   parameter logic [7:0]  DEV_ID    = 8'h3C,                  // Arbitrary value
   parameter logic [7:0]  MEM_TYPE  = 8'h61,                  // Arbitrary value
   parameter logic [7:0]  CAPACITY  = 8'h17,                  // Arbitrary value
   parameter logic [63:0] UNIQUE_ID = 64'h0123_4567_89AB_CDEF // Arbitrary value
) (
   // Clock and reset
   input  wire logic             clock,
   input  wire logic             rst_n,
   // Serial link pins
   input  wire logic             spi_clk,
   input  wire logic             cs_n,
   input  wire logic             serial_in,
   output logic      [3:0]       io_out,
   output logic      [3:0]       io_oe,
   // Erase/program engine
   input  wire logic             prog_busy,
   output logic                  busy,
   // Parameter table load
   input  wire logic             tbl_wr_en,
   input  wire logic [7:0]       tbl_wr_addr,
   input  wire logic [7:0]       tbl_wr_data,
   // Power state
   output fpd_pkg::fpd_pm_t      pm_state
);
   import fpd_pkg::*;

   localparam int DP_B  = `FPD_DP_CYC;
   localparam int RES_B = `FPD_RES_CYC;

   logic [2:0]  pin_s;
   logic        sclk_s;
   logic        cs_s;
   logic        si_s;
   logic        sclk_d_q;
   logic        cs_d_q;
   logic        sck_rise;
   logic        sck_fall;
   logic        cs_rise;
   fpd_ph_t     ph_q;
   fpd_pm_t     pm_q;
   fpd_wid_t    wid_q;
   logic [7:0]  opc_q;
   logic [7:0]  op_w;
   logic [3:0]  bits_q;
   logic        over_q;
   logic [5:0]  cnt_q;
   logic [5:0]  need_q;
   logic [6:0]  need_w;
   logic [7:0]  addr_q;
   logic [11:0] tmr_q;
   logic        busy_q;
   logic [7:0]  tbl_q [256];
   logic [7:0]  idx_q;
   logic [7:0]  tix;
   logic [63:0] uid_w;
   logic [7:0]  byte_w;
   logic        push_ready;
   logic        pop_valid;
   logic        pop_ready;
   logic [7:0]  pop_data;
   logic [7:0]  sh_q;
   logic [3:0]  left_q;
   logic [3:0]  wn;
   logic [3:0]  io_out_q;
   logic [3:0]  io_oe_q;
   logic        exec_pd;
   logic        exec_rel;

   fpd_sync #(.WIDTH(3), .RST(`FPD_PIN_RST)) u_sync (
      .clock (clock),
      .rst_n (rst_n),
      .din   ({spi_clk, cs_n, serial_in}),
      .dout  (pin_s)
   );

   assign {sclk_s, cs_s, si_s} = pin_s;

   always_ff @(posedge clock)
   begin
      if (!rst_n)
      begin
         sclk_d_q <= 1'b0;
         cs_d_q   <= 1'b1;
      end
      else
      begin
         sclk_d_q <= sclk_s;
         cs_d_q   <= cs_s;
      end
   end

   // Edges only count inside a frame
   assign sck_rise = sclk_s && !sclk_d_q && !cs_s;
   assign sck_fall = !sclk_s && sclk_d_q && !cs_s;
   assign cs_rise  = cs_s && !cs_d_q;
   assign op_w     = {opc_q[6:0], si_s};

   // Input clocks after the opcode; bit 6 marks a known read
   function automatic logic [6:0] need_of(input logic [7:0] op);
      unique case (op)
         `FPD_OP_REL: need_of = {1'b1, `FPD_IN_REL};
         `FPD_OP_MD1: need_of = {1'b1, `FPD_IN_MD1};
         `FPD_OP_MD2: need_of = {1'b1, `FPD_IN_MD2};
         `FPD_OP_MD4: need_of = {1'b1, `FPD_IN_MD4};
         `FPD_OP_UID: need_of = {1'b1, `FPD_IN_UID};
         `FPD_OP_JID: need_of = {1'b1, `FPD_IN_JID};
         `FPD_OP_PAR: need_of = {1'b1, `FPD_IN_PAR};
         default:     need_of = 7'h00;
      endcase
   endfunction : need_of

   assign need_w = need_of(op_w);

   // Frame decoder
   always_ff @(posedge clock)
   begin
      if (!rst_n || cs_s)
      begin
         ph_q   <= FPD_PH_OPC;
         bits_q <= 4'h0;
         over_q <= 1'b0;
         cnt_q  <= 6'h00;
      end
      else if (sck_rise)
      begin
         unique case (ph_q)
            FPD_PH_OPC:
            begin
               opc_q  <= op_w; // RULE19
               bits_q <= bits_q + 4'h1;
               if (bits_q == `FPD_OPC_BITS - 4'h1)
               begin
                  need_q <= need_w[5:0];
                  wid_q  <= (op_w == `FPD_OP_MD2) ? FPD_W2 :
                            (op_w == `FPD_OP_MD4) ? FPD_W4 : FPD_W1;
                  // Powered down or releasing: every read is dropped
                  if (pm_q != FPD_PM_NORMAL || !need_w[6]) // RULE3 RULE5
                     ph_q <= FPD_PH_IGN;
                  else if (op_w == `FPD_OP_REL && prog_busy) // RULE9
                     ph_q <= FPD_PH_IGN;
                  else if (need_w[5:0] == 6'h00) // RULE16
                     ph_q <= FPD_PH_OUT;
                  else
                     ph_q <= FPD_PH_IN;
               end
            end
            FPD_PH_IN:
            begin
               over_q <= 1'b1;
               cnt_q  <= cnt_q + 6'h01;
               // Dummy and address clocks; dual/quad mode bits ignored
               if (cnt_q + 6'h01 == need_q) // RULE7 RULE13 RULE14 RULE15 RULE17
                  ph_q <= FPD_PH_OUT;
            end
            FPD_PH_OUT, FPD_PH_IGN:
               over_q <= 1'b1;
         endcase
      end
   end

   // Low address byte of the table read; upper bits are not checked
   always_ff @(posedge clock)
   begin
      if (!rst_n)
         addr_q <= 8'h00;
      else if (sck_rise && ph_q == FPD_PH_IN && opc_q == `FPD_OP_PAR &&
               cnt_q < `FPD_PAR_ADDR)
         addr_q <= {addr_q[6:0], si_s}; // RULE18 RULE19
   end

   assign exec_pd  = cs_rise && bits_q == `FPD_OPC_BITS && !over_q &&
                     opc_q == `FPD_OP_PD; // RULE1
   assign exec_rel = cs_rise && bits_q == `FPD_OPC_BITS && !over_q &&
                     opc_q == `FPD_OP_REL && !prog_busy; // RULE9

   // Power state
   always_ff @(posedge clock)
   begin
      if (!rst_n)
      begin
         pm_q  <= FPD_PM_NORMAL; // RULE4
         tmr_q <= 12'h000;
      end
      else
      begin
         unique case (pm_q)
            FPD_PM_NORMAL:
               if (exec_pd)
               begin
                  pm_q  <= FPD_PM_ENTER;
                  tmr_q <= 12'(DP_B - 1);
               end
            FPD_PM_ENTER:
               if (tmr_q == 12'h000)
                  pm_q <= FPD_PM_DOWN; // RULE2
               else
                  tmr_q <= tmr_q - 12'h001;
            FPD_PM_DOWN:
               if (exec_rel)
               begin
                  pm_q  <= FPD_PM_RELEASE; // RULE5
                  tmr_q <= 12'(RES_B - 1);
               end
            FPD_PM_RELEASE:
               // Frames during this wait are lost, so the host must idle
               if (tmr_q == 12'h000)
                  pm_q <= FPD_PM_NORMAL; // RULE6
               else
                  tmr_q <= tmr_q - 12'h001;
         endcase
      end
   end

   always_ff @(posedge clock)
   begin
      if (!rst_n)
         busy_q <= 1'b0;
      else
         busy_q <= prog_busy; // RULE20
   end

   // Table storage is data, loaded once after power-up
   always_ff @(posedge clock)
   begin
      if (tbl_wr_en)
         tbl_q[tbl_wr_addr] <= tbl_wr_data;
   end

   assign tix   = addr_q + idx_q; // RULE21
   assign uid_w = UNIQUE_ID << {idx_q[2:0], 3'b000};

   always_comb
   begin
      unique case (opc_q)
         `FPD_OP_REL:                         byte_w = DEV_ID; // RULE7 RULE8
         `FPD_OP_MD1, `FPD_OP_MD2, `FPD_OP_MD4:
            byte_w = idx_q[0] ? DEV_ID : MFR_ID; // RULE10 RULE12
         `FPD_OP_UID:                         byte_w = uid_w[63:56]; // RULE15
         `FPD_OP_JID:
            byte_w = (idx_q == 8'h00) ? MFR_ID :
                     (idx_q == 8'h01) ? MEM_TYPE : CAPACITY; // RULE16
         `FPD_OP_PAR:                         byte_w = tbl_q[tix]; // RULE17
         default:                             byte_w = 8'h00;
      endcase
   end

   // Byte producer, stalled by a full FIFO
   always_ff @(posedge clock)
   begin
      if (!rst_n || cs_s)
         idx_q <= 8'h00;
      else if (ph_q == FPD_PH_OUT && push_ready)
      begin
         if (opc_q == `FPD_OP_JID && idx_q == 8'h02)
            idx_q <= 8'h00;
         else
            idx_q <= idx_q + 8'h01; // RULE21
      end
   end

   fpd_fifo #(.WIDTH(8), .DEPTH(16)) u_fifo (
      .clock     (clock),
      .rst_n     (rst_n),
      .flush     (cs_s),
      .in_valid  (ph_q == FPD_PH_OUT),
      .in_ready  (push_ready),
      .in_data   (byte_w),
      .out_valid (pop_valid),
      .out_ready (pop_ready),
      .out_data  (pop_data)
   );

   assign wn        = (wid_q == FPD_W4) ? 4'h4 : (wid_q == FPD_W2) ? 4'h2 : 4'h1;
   assign pop_ready = sck_fall && ph_q == FPD_PH_OUT && left_q == 4'h0;

   // Top bits of a byte onto the data pins for the active width
   function automatic logic [3:0] lanes(input fpd_wid_t w, input logic [7:0] b);
      unique case (w)
         FPD_W1: lanes = {2'b00, b[7], 1'b0};
         FPD_W2: lanes = {2'b00, b[7:6]};
         FPD_W4: lanes = b[7:4];
         default: lanes = 4'h0;
      endcase
   endfunction : lanes

   // Shifter; an empty FIFO holds the pins rather than sending junk
   always_ff @(posedge clock)
   begin
      if (!rst_n || cs_s)
      begin
         left_q   <= 4'h0;
         sh_q     <= 8'h00;
         io_out_q <= 4'h0;
         io_oe_q  <= `FPD_OE_OFF; // RULE22
      end
      else if (sck_fall && ph_q == FPD_PH_OUT)
      begin
         if (left_q == 4'h0)
         begin
            if (pop_valid)
            begin
               io_out_q <= lanes(wid_q, pop_data); // RULE11 RULE14
               sh_q     <= pop_data << wn;
               left_q   <= 4'h8 - wn;
               io_oe_q  <= (wid_q == FPD_W4) ? `FPD_OE_W4 :
                           (wid_q == FPD_W2) ? `FPD_OE_W2 : `FPD_OE_W1;
            end
         end
         else
         begin
            io_out_q <= lanes(wid_q, sh_q);
            sh_q     <= sh_q << wn;
            left_q   <= left_q - wn;
         end
      end
   end

   assign io_out   = io_out_q;
   assign io_oe    = io_oe_q;
   assign busy     = busy_q;
   assign pm_state = pm_q;

   a_pd_needs_frame: assert property (@(posedge clock) disable iff (!rst_n) // RULE1
      cs_rise && pm_q == FPD_PM_NORMAL && (over_q || opc_q != `FPD_OP_PD)
      |=> pm_q == FPD_PM_NORMAL)
      else $error("power-down entered on a bad frame");

   a_pd_entry_time: assert property (@(posedge clock) disable iff (!rst_n) // RULE2
      $rose(pm_q == FPD_PM_ENTER) |-> ##[1:DP_B] pm_q == FPD_PM_DOWN)
      else $error("power-down entry too slow");

   a_pd_silent: assert property (@(posedge clock) disable iff (!rst_n) // RULE3
      pm_q == FPD_PM_DOWN |-> io_oe_q == `FPD_OE_OFF && ph_q != FPD_PH_OUT)
      else $error("output while powered down");

   a_reset_normal: assert property (@(posedge clock) // RULE4
      $rose(rst_n) |-> pm_q == FPD_PM_NORMAL)
      else $error("reset not in normal operation");

   a_release_time: assert property (@(posedge clock) disable iff (!rst_n) // RULE5
      $rose(pm_q == FPD_PM_RELEASE) |-> (pm_q == FPD_PM_RELEASE)[*8]
      ##[1:RES_B] pm_q == FPD_PM_NORMAL)
      else $error("release time wrong");

   a_busy_no_release: assert property (@(posedge clock) disable iff (!rst_n) // RULE9
      pm_q == FPD_PM_DOWN && cs_rise && prog_busy |=> pm_q == FPD_PM_DOWN)
      else $error("release taken while busy");

   a_dual_lanes: assert property (@(posedge clock) disable iff (!rst_n) // RULE11
      opc_q == `FPD_OP_MD2 && ph_q == FPD_PH_OUT && io_oe_q != `FPD_OE_OFF
      |-> io_oe_q == `FPD_OE_W2)
      else $error("dual read on wrong lanes");

   a_quad_lanes: assert property (@(posedge clock) disable iff (!rst_n) // RULE14
      opc_q == `FPD_OP_MD4 && ph_q == FPD_PH_OUT && io_oe_q != `FPD_OE_OFF
      |-> io_oe_q == `FPD_OE_W4)
      else $error("quad read on wrong lanes");

   a_busy_flag: assert property (@(posedge clock) disable iff (!rst_n) // RULE20
      $fell(prog_busy) |=> !busy_q)
      else $error("busy flag stuck");

   a_release_pins: assert property (@(posedge clock) disable iff (!rst_n) // RULE22
      cs_rise |=> io_oe_q == `FPD_OE_OFF && left_q == 4'h0)
      else $error("drivers held after select high");

endmodule : fpd_top

/* File: testbench/fpd_host_model.sv */
/*
 * Host model of the serial link: select, serial clock, serial input.
 * Assumes the bench clock; one serial clock period is 16 clocks.
 */
`timescale 1ns/1ps
module fpd_host_model (
   // Clock
   input  wire logic       clock,
   // Serial link
   output logic            spi_clk,
   output logic            cs_n,
   output logic            serial_in,
   input  wire logic [3:0] io_out,
   input  wire logic [3:0] io_oe
);
   initial
   begin
      spi_clk = 1'b0;
      cs_n = 1'b1;
      serial_in = 1'b0;
   end

   // Bits MSB first, changed while low, taken on the rise
   task automatic send(input logic [31:0] v, input int n);
      for (int i = n - 1; i >= 0; i--)
      begin
         serial_in <= v[i];
         repeat (8) @(posedge clock);
         spi_clk <= 1'b1;
         repeat (8) @(posedge clock);
         spi_clk <= 1'b0;
      end
   endtask : send

   // Sampled at the rise, long after the fall launched the data
   task automatic recv(input int n, input int w, output logic [63:0] d);
      d = '0;
      for (int i = 0; i < n; i++)
      begin
         repeat (8) @(posedge clock);
         if (w == 4)
            d = {d[59:0], io_out};
         else if (w == 2)
            d = {d[61:0], io_out[1:0]};
         else
            d = {d[62:0], io_out[1]};
         spi_clk <= 1'b1;
         repeat (8) @(posedge clock);
         spi_clk <= 1'b0;
      end
   endtask : recv

   task automatic frame(input logic [7:0] op, input logic [31:0] v, input int n,
                        input int rn, input int w, output logic [63:0] d,
                        output logic [3:0] oe);
      @(posedge clock);
      cs_n <= 1'b0;
      repeat (3) @(posedge clock);
      send({24'h0, op}, 8);
      send(v, n);
      recv(rn, w, d);
      repeat (8) @(posedge clock);
      oe = io_oe;
      cs_n <= 1'b1;
      // A released line must not keep its last level
      serial_in <= ~serial_in;
      repeat (6) @(posedge clock);
   endtask : frame
endmodule : fpd_host_model

/* File: testbench/flash_power_down_and_id_cmds_tb_top.sv */
/*
 * Bench of the power-down and identification engine; long reads
 * push the output FIFO into back-pressure through the pins.
 * Assumes the host model drives the link; bench drives the rest.
 */
`timescale 1ns/1ps
`include "fpd_defines.svh"
module flash_power_down_and_id_cmds_tb_top;
   import fpd_pkg::*;
   localparam logic [7:0]  MFR = 8'hA5; // Arbitrary value
   localparam logic [7:0]  DEV = 8'h3C; // Arbitrary value
   localparam logic [7:0]  MEM = 8'h61;
   localparam logic [7:0]  CAP = 8'h17;
   localparam logic [63:0] UID = 64'hFEDC_BA98_7654_3210;
   logic clock, rst_n, spi_clk, cs_n, serial_in, prog_busy, busy, tbl_wr_en;
   logic [3:0] io_out, io_oe, oe;
   logic [7:0] tbl_wr_addr, tbl_wr_data;
   logic [63:0] d;
   fpd_pm_t pm_state;
   int error_cnt, compares;

   fpd_top #(.MFR_ID(MFR), .DEV_ID(DEV), .MEM_TYPE(MEM), .CAPACITY(CAP),
      .UNIQUE_ID(UID)) fpd_top_inst (.clock(clock), .rst_n(rst_n),
      .spi_clk(spi_clk), .cs_n(cs_n), .serial_in(serial_in), .io_out(io_out),
      .io_oe(io_oe), .prog_busy(prog_busy), .busy(busy), .tbl_wr_en(tbl_wr_en),
      .tbl_wr_addr(tbl_wr_addr), .tbl_wr_data(tbl_wr_data), .pm_state(pm_state));
   fpd_host_model fpd_host_model_inst (.clock(clock), .spi_clk(spi_clk),
      .cs_n(cs_n), .serial_in(serial_in), .io_out(io_out), .io_oe(io_oe));

   task automatic chk(input string nm, input logic [63:0] e, input logic [63:0] g);
      compares++;
      if (g !== e)
      begin
         error_cnt++;
         $display("BAD %s expected %h seen %h", nm, e, g);
      end
   endtask : chk

   task automatic results();
      $display("compares %0d errors %0d", compares, error_cnt);
      if (error_cnt == 0 && compares > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask : results

   task automatic wait_pm(input fpd_pm_t s, input int lim);
      int k;
      k = 0;
      while (pm_state !== s && k < lim)
      begin
         @(posedge clock);
         #1;
         k++;
      end
      chk("pm_state", s, pm_state);
      if (pm_state !== s)
         results();
   endtask : wait_pm

   task automatic rd(input logic [7:0] op, input logic [31:0] v, input int n,
                     input int rn, input int w);
      fpd_host_model_inst.frame(op, v, n, rn, w, d, oe);
   endtask : rd

   task automatic t_ids();
      rd(`FPD_OP_JID, 0, 0, 48, 1);
      chk("jedec", {16'h0, MFR, MEM, CAP, MFR, MEM, CAP}, d);
      chk("oe x1", 4'h2, oe);
      chk("oe idle", 4'h0, io_oe);
      rd(`FPD_OP_REL, 0, 24, 24, 1);
      chk("devid", {40'h0, DEV, DEV, DEV}, d);
      rd(`FPD_OP_MD1, 0, 24, 32, 1);
      chk("mfr x1", {32'h0, MFR, DEV, MFR, DEV}, d);
      rd(`FPD_OP_MD2, 32'h000C, 16, 24, 2);
      chk("mfr x2", {16'h0, {3{MFR, DEV}}}, d);
      chk("oe x2", 4'h3, oe);
      rd(`FPD_OP_MD4, 32'h080, 12, 16, 4);
      chk("mfr x4", {4{MFR, DEV}}, d);
      chk("oe x4", 4'hF, oe);
      rd(`FPD_OP_UID, 0, 32, 64, 1);
      chk("uid", UID, d);
      // Partial byte at select rise
      rd(`FPD_OP_JID, 0, 0, 5, 1);
      chk("oe cut", 4'h0, io_oe);
   endtask : t_ids

   task automatic t_table();
      for (int i = 0; i < 256; i++)
      begin
         @(posedge clock);
         tbl_wr_en <= 1'b1;
         tbl_wr_addr <= i[7:0];
         tbl_wr_data <= i[7:0] ^ 8'hC3;
      end
      @(posedge clock);
      tbl_wr_en <= 1'b0;
      rd(`FPD_OP_PAR, 32'h0000_FE00, 32, 24, 1);
      chk("table", {40'h0, 8'hFE ^ 8'hC3, 8'hFF ^ 8'hC3, 8'hC3}, d);
   endtask : t_table

   task automatic t_power();
      rd(`FPD_OP_PD, 0, 1, 0, 1);
      repeat (`FPD_DP_CYC + 20) @(posedge clock);
      chk("pd nine", FPD_PM_NORMAL, pm_state);
      rd(`FPD_OP_PD, 0, 0, 0, 1);
      wait_pm(FPD_PM_DOWN, `FPD_DP_CYC + 10);
      rd(`FPD_OP_JID, 0, 0, 24, 1);
      chk("oe down", 4'h0, oe);
      @(posedge clock);
      prog_busy <= 1'b1;
      repeat (2) @(posedge clock);
      #1 chk("busy", 1'b1, busy);
      rd(`FPD_OP_REL, 0, 0, 0, 1);
      chk("rel busy", FPD_PM_DOWN, pm_state);
      @(posedge clock);
      prog_busy <= 1'b0;
      repeat (2) @(posedge clock);
      #1 chk("idle", 1'b0, busy);
      rd(`FPD_OP_REL, 0, 0, 0, 1);
      chk("release", FPD_PM_RELEASE, pm_state);
      // Select stays high for the whole release time
      wait_pm(FPD_PM_NORMAL, `FPD_RES_CYC + 10);
      rd(`FPD_OP_JID, 0, 0, 24, 1);
      chk("jedec up", {40'h0, MFR, MEM, CAP}, d);
      @(posedge clock);
      prog_busy <= 1'b1;
      rd(`FPD_OP_REL, 0, 24, 16, 1);
      chk("oe busy", 4'h0, oe);
      @(posedge clock);
      prog_busy <= 1'b0;
   endtask : t_power

   // Twenty bytes outrun the 16-byte FIFO, so the producer must stall
   task automatic t_fifo();
      rd(`FPD_OP_MD1, 0, 24, 160, 1);
      chk("stream x1", {4{MFR, DEV}}, d);
      chk("stream oe", 4'h2, oe);
      rd(`FPD_OP_UID, 0, 32, 160, 1);
      chk("uid wrap", {UID[31:0], UID[63:32]}, d);
      chk("drained", 4'h0, io_oe);
   endtask : t_fifo

   // Reset in mid-run from power-down comes back in normal operation
   task automatic t_reset();
      rd(`FPD_OP_PD, 0, 0, 0, 1);
      wait_pm(FPD_PM_DOWN, `FPD_DP_CYC + 10);
      @(posedge clock);
      rst_n <= 1'b0;
      repeat (2) @(posedge clock);
      rst_n <= 1'b1;
      @(posedge clock);
      #1 chk("pm rerst", FPD_PM_NORMAL, pm_state);
      repeat (3) @(posedge clock);
      rd(`FPD_OP_JID, 0, 0, 24, 1);
      chk("jedec rerst", {40'h0, MFR, MEM, CAP}, d);
   endtask : t_reset

   initial
   begin
      clock = 1'b0;
      forever #5 clock = ~clock;
   end

   initial
   begin
      error_cnt = 0;
      compares = 0;
      rst_n = 1'b0;
      prog_busy = 1'b0;
      tbl_wr_en = 1'b0;
      tbl_wr_addr = 8'h00;
      tbl_wr_data = 8'h00;
      repeat (2) @(posedge clock);
      rst_n <= 1'b1;
      @(posedge clock);
      #1 chk("pm reset", FPD_PM_NORMAL, pm_state);
      chk("oe reset", 4'h0, io_oe);
      repeat (3) @(posedge clock);
      t_ids();
      t_table();
      t_power();
      t_fifo();
      t_reset();
      results();
   end
endmodule : flash_power_down_and_id_cmds_tb_top
